// >>> bench/eag_far_side.sv
// Register file and extension word source facing the generator.
// Assumes the bench preloads regs and queues words in instruction order.
`timescale 1ns/1ps
module eag_far_side (
	// Clock
	input  wire logic        core_clk,
	// Extension word stream
	input  wire logic        ext_req,
	output logic             ext_valid,
	output logic [15:0]      ext_word,
	// Register file
	input  wire logic [4:0]  reg_rd_sel,
	output logic [31:0]      reg_rd_data,
	input  wire logic        reg_wr_en,
	input  wire logic [4:0]  reg_wr_sel,
	input  wire logic [31:0] reg_wr_data
);
	logic [31:0] regs [0:16];
	logic [15:0] words [$];
	initial begin
		ext_valid = 1'b0;
		ext_word = 16'h5A5A;
	end
	assign reg_rd_data = regs[reg_rd_sel];
	// Random gaps give slow answers; an offer stays up until taken
	always @(negedge core_clk)
		if (!ext_valid && ext_req && words.size() > 0 && $urandom % 2) begin
			ext_valid <= 1'b1;
			ext_word <= words[0];
		end
	always @(posedge core_clk) begin
		if (ext_req && ext_valid) begin
			void'(words.pop_front());
			ext_valid <= 1'b0;
			ext_word <= ~ext_word;
		end
		if (reg_wr_en)
			regs[reg_wr_sel] <= reg_wr_data;
	end
endmodule

// >>> bench/eag_top_properties.sv
// Port-level checks for the effective address generator.
// Assumes one core_clk domain; bound to eag_top at the foot of this file.
`timescale 1ns/1ps
module eag_top_properties
	import eag_pkg::*;
(
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        arst_n,
	// Request and result
	input  wire logic        req_valid,
	input  wire eag_req_t    req,
	input  wire logic        req_ready,
	input  wire logic        done,
	input  wire eag_res_t    result,
	// Register write port
	input  wire logic        reg_wr_en,
	input  wire logic [31:0] reg_wr_data
);
	wire logic       take = req_valid && req_ready;
	wire logic [2:0] md   = req.op_word[EA_MODE_HI:EA_MODE_LO];
	wire logic [2:0] rg   = req.op_word[EA_REG_HI:EA_REG_LO];
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	a_data_dir_sel: assert property (take && md == MODE_DATA_DIR |=>
		done && result.kind == KIND_REGISTER && result.reg_sel == {2'h0, $past(rg)}) else $error("data select wrong");
	a_addr_dir_sel: assert property (take && md == MODE_ADDR_DIR && rg != STACK_REG_NUM |=>
		done && result.kind == KIND_REGISTER && result.reg_sel == REG_ADDR_BASE + {2'h0, $past(rg)})
		else $error("address select wrong");
	a_stack_map_sel: assert property (take && md == MODE_ADDR_DIR && rg == STACK_REG_NUM |=>
		result.reg_sel == ($past(req.supervisor) ? REG_SUPER_SP : REG_USER_SP)) else $error("stack map wrong");
	a_direct_no_write: assert property (take && md <= MODE_ADDR_DIR |=> !reg_wr_en)
		else $error("write on direct mode");
	a_illegal_flag_set: assert property (take && md == MODE_SPECIAL && rg > SUB_IMMEDIATE |=>
		done && result.illegal) else $error("illegal not flagged");
	a_indirect_two_cycles: assert property (take && md == MODE_IND |-> ##2
		done && result.kind == KIND_MEMORY && !reg_wr_en) else $error("indirect answer wrong");
	a_sp_byte_step: assert property (take && md == MODE_POSTINC && rg == STACK_REG_NUM &&
		req.size == SIZE_BYTE |-> ##2
		done && reg_wr_en && reg_wr_data == result.addr + STEP_TWO) else $error("stack byte step wrong");
	a_predec_write_back: assert property (take && md == MODE_PREDEC |-> ##2
		done && reg_wr_en && reg_wr_data == result.addr) else $error("predecrement write wrong");
endmodule

bind eag_top eag_top_properties u_props (
	.core_clk    (core_clk),
	.arst_n      (arst_n),
	.req_valid   (req_valid),
	.req         (req),
	.req_ready   (req_ready),
	.done        (done),
	.result      (result),
	.reg_wr_en   (reg_wr_en),
	.reg_wr_data (reg_wr_data)
);

// >>> bench/test_effective_address_generator.sv
// Random self-checking bench for the effective address generator.
// Assumes eag_far_side models the register file and word source.
`timescale 1ns/1ps
module test_effective_address_generator;
	import eag_pkg::*;
	typedef struct packed {
		logic        ill;
		eag_kind_t   kind;
		logic [31:0] v;
		logic        pref;
		logic        wchk;
		logic [4:0]  wsel;
		logic [31:0] wval;
	} eag_exp_t;
	logic core_clk = 1'b0, arst_n = 1'b0, req_valid = 1'b0;
	logic req_ready, ext_req, ext_valid, reg_wr_en, done;
	logic [15:0] ext_word;
	logic [4:0]  reg_rd_sel, reg_wr_sel;
	logic [31:0] reg_rd_data, reg_wr_data;
	eag_req_t    req = '0;
	eag_res_t    result;
	logic [31:0] m [0:16];
	eag_exp_t    exp_q [$];
	int          err_count = 0, checks = 0;
	bit          stuck = 1'b0;

	eag_top DUT (.core_clk(core_clk), .arst_n(arst_n), .req_valid(req_valid), .req(req), .req_ready(req_ready),
		.ext_req(ext_req), .ext_valid(ext_valid), .ext_word(ext_word), .reg_rd_sel(reg_rd_sel),
		.reg_rd_data(reg_rd_data), .reg_wr_en(reg_wr_en), .reg_wr_sel(reg_wr_sel), .reg_wr_data(reg_wr_data),
		.done(done), .result(result));
	eag_far_side far (.core_clk(core_clk), .ext_req(ext_req), .ext_valid(ext_valid), .ext_word(ext_word),
		.reg_rd_sel(reg_rd_sel), .reg_rd_data(reg_rd_data), .reg_wr_en(reg_wr_en), .reg_wr_sel(reg_wr_sel),
		.reg_wr_data(reg_wr_data));

	initial forever #50 core_clk = ~core_clk;

	task automatic report_and_stop();
		if (err_count == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		checks++;
		if (seen !== want) begin
			err_count++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, want);
		end
	endtask

	function automatic logic [4:0] cd(input logic a, input logic [2:0] n, input logic s);
		cd = !a ? {2'h0, n} : n != STACK_REG_NUM ? REG_ADDR_BASE + {2'h0, n} : s ? REG_SUPER_SP : REG_USER_SP;
	endfunction

	// Called at a falling edge; leaves the request up so the next one can follow back to back
	task automatic run();
		logic [2:0]  md, r;
		logic [31:0] a, ix, t;
		logic [15:0] w0, w1;
		eag_exp_t    e;
		int          n;
		md = 3'($urandom % 8);
		r = ($urandom % 2) ? 3'h7 : 3'($urandom % 8);
		w0 = 16'($urandom);
		w1 = 16'($urandom);
		req.op_word = {10'($urandom), md, r};
		req.size = eag_size_t'($urandom % 3);
		req.is_jump = 1'($urandom);
		req.supervisor = 1'($urandom);
		req.ext_addr = $urandom & 32'hFFFF_FFFE;
		req.status_sel = md == MODE_SPECIAL && r == SUB_IMMEDIATE && ($urandom % 2);
		a = m[cd(1'b1, r, req.supervisor)];
		ix = w0[15] ? m[cd(1'b1, w0[14:12], req.supervisor)] : m[w0[14:12]];
		if (!w0[11])
			ix = {{16{ix[15]}}, ix[15:0]};
		t = req.size == SIZE_BYTE ? (r == STACK_REG_NUM ? STEP_TWO : STEP_ONE) : req.size == SIZE_WORD ? STEP_TWO : STEP_FOUR;
		e = '0;
		e.kind = KIND_MEMORY;
		e.pref = req.is_jump;
		e.wsel = cd(1'b1, r, req.supervisor);
		n = 0;
		case (md)
			3'h0, 3'h1: begin
				e.kind = KIND_REGISTER;
				e.v = {27'h0, cd(md[0], r, req.supervisor)};
			end
			3'h2: e.v = a;
			3'h3, 3'h4: begin
				e.v = md[0] ? a : a - t;
				e.wval = md[0] ? a + t : a - t;
				e.pref = 1'b0;
				e.wchk = 1'b1;
				m[e.wsel] = e.wval;
			end
			3'h5: {n, e.v} = {32'd1, a + {{16{w0[15]}}, w0}};
			3'h6: {n, e.v} = {32'd1, a + {{24{w0[7]}}, w0[7:0]} + ix};
			default: case (r)
				3'h0: {n, e.v} = {32'd1, {{16{w0[15]}}, w0}};
				3'h1: {n, e.v} = {32'd2, w0, w1};
				3'h2: {n, e.pref, e.v} = {32'd1, 1'b1, req.ext_addr + {{16{w0[15]}}, w0}};
				3'h3: {n, e.pref, e.v} = {32'd1, 1'b1, req.ext_addr + {{24{w0[7]}}, w0[7:0]} + ix};
				3'h4: begin
					e.kind = req.status_sel ? KIND_STATUS : KIND_IMMEDIATE;
					n = req.status_sel ? 0 : req.size == SIZE_LONG ? 2 : 1;
					e.v = req.size == SIZE_BYTE ? {24'h0, w0[7:0]} : req.size == SIZE_WORD ? {16'h0, w0} : {w0, w1};
				end
				default: e.ill = 1'b1;
			endcase
		endcase
		if (n > 0)
			far.words.push_back(w0);
		if (n > 1)
			far.words.push_back(w1);
		exp_q.push_back(e);
		req_valid = 1'b1;
		for (n = 0; req_ready !== 1'b1; n++) begin
			if (n > 60) begin
				err_count++;
				$display("unexpected at %0t: request not taken", $time);
				stuck = 1'b1;
				return;
			end
			@(negedge core_clk);
		end
		@(negedge core_clk);
	endtask

	always @(negedge core_clk)
		if (arst_n && done === 1'b1) begin
			eag_exp_t e;
			if (exp_q.size() == 0)
				chk(32'h0, 32'h1);
			else begin
				e = exp_q.pop_front();
				chk(result.illegal, e.ill);
				if (!e.ill)
					chk(result.kind, e.kind);
				if (!e.ill && e.kind == KIND_REGISTER)
					chk(result.reg_sel, e.v);
				if (!e.ill && e.kind == KIND_MEMORY) begin
					chk(result.addr, e.v);
					chk(result.program_ref, e.pref);
				end
				if (!e.ill && e.kind == KIND_IMMEDIATE)
					chk(result.imm, e.v);
				chk(reg_wr_en, e.wchk);
				if (e.wchk) begin
					chk(reg_wr_sel, e.wsel);
					chk(reg_wr_data, e.wval);
				end
			end
		end

	initial begin
		void'($urandom(1382));
		for (int i = 0; i < 17; i++)
			m[i] = $urandom;
		far.regs = m;
		repeat (12) @(negedge core_clk);
		arst_n = 1'b1;
		for (int i = 0; i < 400 && !stuck; i++)
			run();
		req_valid = 1'b0;
		for (int i = 0; i < 100 && exp_q.size() > 0; i++)
			@(negedge core_clk);
		if (exp_q.size() > 0) begin
			err_count++;
			$display("unexpected at %0t: results missing", $time);
		end
		report_and_stop();
	end
endmodule

// >>> verilog/eag_pkg.sv
// Shared types and constants for the effective address generator.
// Assumes a single processor clock domain and a 32-bit address space.
package eag_pkg;

	// Operation word field layout
	localparam int EA_MODE_HI = 5;
	localparam int EA_MODE_LO = 3;
	localparam int EA_REG_HI  = 2;
	localparam int EA_REG_LO  = 0;

	// Mode field values
	localparam logic [2:0] MODE_DATA_DIR = 3'h0;
	localparam logic [2:0] MODE_ADDR_DIR = 3'h1;
	localparam logic [2:0] MODE_IND      = 3'h2;
	localparam logic [2:0] MODE_POSTINC  = 3'h3;
	localparam logic [2:0] MODE_PREDEC   = 3'h4;
	localparam logic [2:0] MODE_DISP     = 3'h5;
	localparam logic [2:0] MODE_INDEX    = 3'h6;
	localparam logic [2:0] MODE_SPECIAL  = 3'h7;

	// Sub-mode values under the special mode
	localparam logic [2:0] SUB_ABS_SHORT = 3'h0;
	localparam logic [2:0] SUB_ABS_LONG  = 3'h1;
	localparam logic [2:0] SUB_PC_DISP   = 3'h2;
	localparam logic [2:0] SUB_PC_INDEX  = 3'h3;
	localparam logic [2:0] SUB_IMMEDIATE = 3'h4;

	// Register selection codes towards the register file
	localparam logic [4:0] REG_DATA_BASE = 5'h00;
	localparam logic [4:0] REG_ADDR_BASE = 5'h08;
	localparam logic [4:0] REG_USER_SP   = 5'h0F;
	localparam logic [4:0] REG_SUPER_SP  = 5'h10;
	localparam logic [2:0] STACK_REG_NUM = 3'h7;

	// Index extension word layout
	localparam int IDX_IS_ADDR = 15;
	localparam int IDX_REG_HI  = 14;
	localparam int IDX_REG_LO  = 12;
	localparam int IDX_IS_LONG = 11;

	// Step sizes
	localparam logic [31:0] STEP_ONE  = 32'h0000_0001;
	localparam logic [31:0] STEP_TWO  = 32'h0000_0002;
	localparam logic [31:0] STEP_FOUR = 32'h0000_0004;

	typedef enum logic [1:0] {
		SIZE_BYTE = 2'h0,
		SIZE_WORD = 2'h1,
		SIZE_LONG = 2'h2
	} eag_size_t;

	typedef enum logic [1:0] {
		KIND_REGISTER  = 2'h0,
		KIND_MEMORY    = 2'h1,
		KIND_IMMEDIATE = 2'h2,
		KIND_STATUS    = 2'h3
	} eag_kind_t;

	typedef struct packed {
		logic [15:0] op_word;
		eag_size_t   size;
		logic        is_jump;
		logic        status_sel;
		logic        supervisor;
		logic [31:0] ext_addr;
	} eag_req_t;

	typedef struct packed {
		eag_kind_t   kind;
		logic [4:0]  reg_sel;
		logic [31:0] addr;
		logic        program_ref;
		logic [31:0] imm;
		logic        illegal;
	} eag_res_t;

	function automatic logic [4:0] reg_code(input logic is_addr, input logic [2:0] num,
		input logic supervisor);
		if (!is_addr)
			reg_code = REG_DATA_BASE + {2'h0, num};
		else if (num != STACK_REG_NUM)
			reg_code = REG_ADDR_BASE + {2'h0, num};
		else
			reg_code = supervisor ? REG_SUPER_SP : REG_USER_SP;
	endfunction

	function automatic logic [31:0] sext16(input logic [15:0] v);
		sext16 = {{16{v[15]}}, v};
	endfunction

	function automatic logic [31:0] sext8(input logic [7:0] v);
		sext8 = {{24{v[7]}}, v};
	endfunction

endpackage

// >>> verilog/eag_top.sv
// Effective address generator: decodes the operand field of an operation
// word, fetches extension words and registers, and reports the operand.
// Assumes the sequencer, register file and word source share core_clk;
// register reads return data exactly one cycle after the select is set.
// The sequencer holds each request until it sees req_ready high;
// offers made while req_ready is low never start a decode.
//
// Contract
// - Split the address field into a three-bit mode and three-bit register.
// - Take needed extension words from those following the operation word.
// - Register direct modes name one of sixteen registers, no memory access.
// - Data register direct uses the data register named by the field.
// - Address register direct uses the address register named by the field.
// - Indirect uses register contents as address; data ref except jumps.
// - Post-increment addresses with register, then adds one, two or four.
// - Post-increment byte through stack pointer adds two.
// - Pre-decrement subtracts by size first; byte via stack pointer subtracts two.
// - Displacement mode adds sign-extended 16-bit extension to register.
// - Index mode adds register, sign-extended low byte and index register.
// - Special modes use the register field as sub-mode selector.
// - Absolute short sign-extends one 16-bit extension word.
// - Absolute long joins two words, first word is the high half.
// - PC displacement adds extension to its own address; program reference.
// - PC index adds extension address, low byte and index; program reference.
// - Immediate byte, word or long come from one or two extension words.
// - Status register instructions let the address field select the status register.
// - Modes zero to six decode as the seven register-based modes.
// - Under mode seven, register values zero to four are the special modes.
// - Address register seven maps to supervisor or user stack pointer.
`timescale 1ns/1ps
module eag_top
	import eag_pkg::*;
(
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       arst_n,
	// Request from the sequencer
	input  wire logic       req_valid,
	input  wire eag_req_t   req,
	output logic            req_ready,
	// Extension word stream
	output logic            ext_req,
	input  wire logic       ext_valid,
	input  wire logic [15:0] ext_word,
	// Register file read port
	output logic [4:0]      reg_rd_sel,
	input  wire logic [31:0] reg_rd_data,
	// Register file write port for side effects
	output logic            reg_wr_en,
	output logic [4:0]      reg_wr_sel,
	output logic [31:0]     reg_wr_data,
	// Result
	output logic            done,
	output eag_res_t        result
);

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_BASE,
		ST_EXT1,
		ST_EXT2,
		ST_INDEX
	} eag_state_t;

	logic        rst_meta_n;
	logic        rst_n;
	eag_state_t  state;
	eag_state_t  next_state;
	eag_req_t    cur;
	logic [31:0] acc;
	logic [31:0] next_acc;
	logic [15:0] first_word;
	logic        next_ext_req;
	logic [4:0]  next_rd_sel;
	logic        next_wr_en;
	logic [4:0]  next_wr_sel;
	logic [31:0] next_wr_data;
	logic        next_done;
	eag_res_t    next_result;

	logic [2:0]  mode;
	logic [2:0]  regf;
	logic [2:0]  req_mode;
	logic [2:0]  req_regf;
	logic        ext_take;
	logic        is_sp;
	logic [31:0] step;
	logic        mem_ref;

	logic        req_take;
	logic        pc_mode;
	logic [31:0] dec_addr;

	// Both halves of a two-word extension, first word on top
	function automatic logic [31:0] join_words(input logic [15:0] hi, input logic [15:0] lo);
		join_words = {hi, lo};
	endfunction

	// A word-sized index contributes only its sign-extended low half
	function automatic logic [31:0] index_value(input logic is_long, input logic [31:0] data);
		index_value = is_long ? data : sext16(data[15:0]);
	endfunction

	// Release reset through two flops so removal is clean to core_clk
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_meta_n <= 1'b0;
			rst_n      <= 1'b0;
		end else begin
			rst_meta_n <= 1'b1;
			rst_n      <= rst_meta_n;
		end
	end

	assign req_mode = req.op_word[EA_MODE_HI:EA_MODE_LO];
	assign req_regf = req.op_word[EA_REG_HI:EA_REG_LO];
	assign mode     = cur.op_word[EA_MODE_HI:EA_MODE_LO];
	assign regf     = cur.op_word[EA_REG_HI:EA_REG_LO];
	assign ext_take = ext_req && ext_valid;
	assign is_sp    = (regf == STACK_REG_NUM);

	// Gating on ready keeps a held offer from being taken twice
	assign req_take = req_valid && req_ready;
	assign pc_mode  = (mode == MODE_SPECIAL) && ((regf == SUB_PC_DISP) || (regf == SUB_PC_INDEX));
	assign dec_addr = reg_rd_data - step;

	// Byte steps through the stack pointer keep it word aligned
	always_comb begin
		unique case (cur.size)
			SIZE_BYTE: step = is_sp ? STEP_TWO : STEP_ONE;
			SIZE_WORD: step = STEP_TWO;
			default:   step = STEP_FOUR;
		endcase
	end

	// Memory modes that a jump turns into program references
	assign mem_ref = (mode == MODE_IND) || (mode == MODE_DISP) || (mode == MODE_INDEX) ||
		((mode == MODE_SPECIAL) && ((regf == SUB_ABS_SHORT) || (regf == SUB_ABS_LONG)));

	always_comb begin
		next_state   = state;
		next_acc     = acc;
		next_ext_req = 1'b0;
		next_rd_sel  = reg_rd_sel;
		next_wr_en   = 1'b0;
		next_wr_sel  = reg_wr_sel;
		next_wr_data = reg_wr_data;
		next_done    = 1'b0;
		next_result  = result;
		unique case (state)
			ST_IDLE: begin
				if (req_take) begin
					next_result         = '0;
					next_result.kind    = KIND_MEMORY;
					next_result.reg_sel = reg_code(req_mode != MODE_DATA_DIR, req_regf,
						req.supervisor);
					// Direct, illegal and status answers finish at once
					unique case (req_mode)
						MODE_DATA_DIR, MODE_ADDR_DIR: begin
							next_result.kind = KIND_REGISTER;
							next_done        = 1'b1;
						end
						MODE_SPECIAL: begin
							if (req_regf > SUB_IMMEDIATE) begin
								next_result.illegal = 1'b1;
								next_done           = 1'b1;
							end else if (req_regf == SUB_IMMEDIATE && req.status_sel) begin
								next_result.kind = KIND_STATUS;
								next_done        = 1'b1;
							end else begin
								next_state   = ST_EXT1;
								next_ext_req = 1'b1;
							end
						end
						default: begin
							next_rd_sel = reg_code(1'b1, req_regf, req.supervisor);
							next_state  = ST_BASE;
						end
					endcase
				end
			end
			ST_BASE: begin
				// Register contents arrive one cycle after the select
				next_acc = reg_rd_data;
				unique case (mode)
					MODE_IND: begin
						next_result.addr        = reg_rd_data;
						next_result.program_ref = cur.is_jump;
						next_done               = 1'b1;
						next_state              = ST_IDLE;
					end
					MODE_POSTINC: begin
						// Write-back lands with done, before any later read
						next_result.addr = reg_rd_data;
						next_wr_en       = 1'b1;
						next_wr_sel      = reg_rd_sel;
						next_wr_data     = reg_rd_data + step;
						next_done        = 1'b1;
						next_state       = ST_IDLE;
					end
					MODE_PREDEC: begin
						next_result.addr = dec_addr;
						next_wr_en       = 1'b1;
						next_wr_sel      = reg_rd_sel;
						next_wr_data     = dec_addr;
						next_done        = 1'b1;
						next_state       = ST_IDLE;
					end
					default: begin
						next_state   = ST_EXT1;
						next_ext_req = 1'b1;
					end
				endcase
			end
			ST_EXT1: begin
				// ext_req falls on the edge that takes the last word needed
				next_ext_req = !ext_valid;
				if (ext_take) begin
					next_done  = 1'b1;
					next_state = ST_IDLE;
					if (mode == MODE_DISP) begin
						next_result.addr = acc + sext16(ext_word);
					end else if (mode == MODE_INDEX || regf == SUB_PC_INDEX) begin
						// PC-relative base is the extension word's own address
						next_acc = ((mode == MODE_INDEX) ? acc : cur.ext_addr)
							+ sext8(ext_word[7:0]);
						next_rd_sel = reg_code(ext_word[IDX_IS_ADDR],
							ext_word[IDX_REG_HI:IDX_REG_LO], cur.supervisor);
						next_done  = 1'b0;
						next_state = ST_INDEX;
					end else begin
						unique case (regf)
							SUB_ABS_SHORT: next_result.addr = sext16(ext_word);
							SUB_PC_DISP: begin
								next_result.addr = cur.ext_addr + sext16(ext_word);
							end
							SUB_ABS_LONG: begin
								// ext_req stays up between the two words
								next_done    = 1'b0;
								next_state   = ST_EXT2;
								next_ext_req = 1'b1;
							end
							default: begin
								next_result.kind = KIND_IMMEDIATE;
								if (cur.size == SIZE_BYTE)
									next_result.imm = {24'h00_0000, ext_word[7:0]};
								else if (cur.size == SIZE_WORD)
									next_result.imm = {16'h0000, ext_word};
								else begin
									next_done    = 1'b0;
									next_state   = ST_EXT2;
									next_ext_req = 1'b1;
								end
							end
						endcase
					end
				end
				next_result.program_ref = pc_mode ||
					(cur.is_jump && mem_ref);
			end
			ST_EXT2: begin
				next_ext_req = !ext_valid;
				if (ext_take) begin
					// Second word fills the low half
					if (regf == SUB_ABS_LONG)
						next_result.addr = join_words(first_word, ext_word);
					else
						next_result.imm = join_words(first_word, ext_word);
					next_done  = 1'b1;
					next_state = ST_IDLE;
				end
			end
			ST_INDEX: begin
				// Index register was selected on the previous edge
				next_result.addr        = acc + index_value(first_word[IDX_IS_LONG],
					reg_rd_data);
				next_result.program_ref = pc_mode || cur.is_jump;
				next_done  = 1'b1;
				next_state = ST_IDLE;
			end
			default: next_state = ST_IDLE;
		endcase
	end

	// Sequencing
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			state <= ST_IDLE;
		else
			state <= next_state;
	end

	// Request capture; an offer is only taken while ready is high
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cur       <= '0;
			req_ready <= 1'b0;
		end else begin
			if (state == ST_IDLE && req_take)
				cur <= req;
			req_ready <= (next_state == ST_IDLE) && !(state == ST_IDLE && req_take);
		end
	end

	// Address accumulator and first extension word
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			acc        <= '0;
			first_word <= '0;
		end else begin
			acc <= next_acc;
			if (state == ST_EXT1 && ext_take)
				first_word <= ext_word;
		end
	end

	// Extension word request and register file ports
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ext_req     <= 1'b0;
			reg_rd_sel  <= '0;
			reg_wr_en   <= 1'b0;
			reg_wr_sel  <= '0;
			reg_wr_data <= '0;
		end else begin
			ext_req     <= next_ext_req;
			reg_rd_sel  <= next_rd_sel;
			reg_wr_en   <= next_wr_en;
			reg_wr_sel  <= next_wr_sel;
			reg_wr_data <= next_wr_data;
		end
	end

	// Result and completion pulse
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			done   <= 1'b0;
			result <= '0;
		end else begin
			done   <= next_done;
			result <= next_result;
		end
	end

endmodule
